// ==== wlc_top.sv ====
// wake line controller: edge detect, pending flags, wake masks, event out
// assumes apb master on clk_sys; pins and direct lines arrive asynchronously
//
// The APB register port was decided locally.
`timescale 1ns/10ps
module wlc_top (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] port_a_pins,
    input wire logic [15:0] port_b_pins,
    input wire logic [15:0] port_c_pins,
    input wire logic [15:0] port_d_pins,
    input wire logic [15:0] port_f_pins,
    input wire logic [1:0] comparator_out,
    input wire logic [9:0] direct_wake_req,
    output logic [17:0] line_irq,
    output logic cpu_event,
    output logic cpu_wake,
    output logic [15:0] mux_out
);
    typedef struct packed {
        logic [17:0] rise;
        logic [17:0] fall;
        logic [17:0] pend;
        logic [31:0] sel_lo;
        logic [31:0] sel_hi;
        logic [31:0] imask;
        logic [31:0] emask;
        logic [17:0] samp;
        logic [31:0] dir_prev;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic evt;
        logic wake;
    } wlc_state_t;

    wlc_state_t st_reg;
    wlc_state_t st_next;

    logic [wlc_pkg::SYNC_W-1:0] sync_q;
    logic [17:0] cur_lvl;
    logic [31:0] dir_lvl;
    logic [17:0] cfg_edge;
    logic [17:0] pend_set;
    logic [17:0] pend_clr;
    logic evt_req;
    logic wake_req;
    logic setup_ph;
    logic access_ph;

    // every outside level is synchronised before any logic looks at it
    wlc_sync #(
        .W(wlc_pkg::SYNC_W)
    ) u_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .d({direct_wake_req, comparator_out, port_f_pins, port_d_pins,
            port_c_pins, port_b_pins, port_a_pins}),
        .q(sync_q)
    );

    // reserved or unsupported codes pick a constant low, so no false edges
    function automatic logic mux_pick(input logic [2:0] code, input int line,
                                      input logic [4:0] pins);
        logic bit_out;
        bit_out = 1'b0;
        unique case (code)
            wlc_pkg::PORT_A: bit_out = pins[0];
            wlc_pkg::PORT_B: bit_out = pins[1];
            wlc_pkg::PORT_C: bit_out = (line != wlc_pkg::NO_C_LINE) & pins[2];
            wlc_pkg::PORT_D: bit_out = (line <= wlc_pkg::LAST_D_LINE) & pins[3];
            wlc_pkg::PORT_F: bit_out = (line <= wlc_pkg::LAST_F_LINE) & pins[4];
            default: bit_out = 1'b0;
        endcase
        return bit_out;
    endfunction

    function automatic logic [2:0] sel_field(input logic [31:0] word, input int idx);
        return word[idx * wlc_pkg::SEL_PITCH +: 3];
    endfunction

    function automatic logic [31:0] read_word(input logic [11:0] addr,
                                              input wlc_state_t s);
        logic [31:0] w;
        w = 32'h00000000;
        unique case (addr)
            wlc_pkg::OFS_RISE: w = {14'h0000, s.rise};
            wlc_pkg::OFS_FALL: w = {14'h0000, s.fall};
            wlc_pkg::OFS_PEND: w = {14'h0000, s.pend};
            wlc_pkg::OFS_SEL_LO: w = s.sel_lo;
            wlc_pkg::OFS_SEL_HI: w = s.sel_hi;
            wlc_pkg::OFS_IMASK: w = s.imask;
            wlc_pkg::OFS_EMASK: w = s.emask;
            default: w = 32'h00000000;
        endcase
        return w;
    endfunction

    function automatic logic addr_hit(input logic [11:0] addr);
        return (addr == wlc_pkg::OFS_RISE) || (addr == wlc_pkg::OFS_FALL) ||
               (addr == wlc_pkg::OFS_PEND) || (addr == wlc_pkg::OFS_SEL_LO) ||
               (addr == wlc_pkg::OFS_SEL_HI) || (addr == wlc_pkg::OFS_IMASK) ||
               (addr == wlc_pkg::OFS_EMASK);
    endfunction

    // gpio mux, one per line, over the synchronised pins
    genvar gi;
    generate
        for (gi = 0; gi < wlc_pkg::GPIO_LINES; gi++) begin : g_mux
            logic [2:0] code;
            assign code = (gi < wlc_pkg::SEL_FIELDS) ? sel_field(st_reg.sel_lo, gi)
                                                     : sel_field(st_reg.sel_hi,
                                                                 gi - wlc_pkg::SEL_FIELDS);
            assign cur_lvl[gi] = mux_pick(code, gi, {sync_q[64 + gi], sync_q[48 + gi],
                                                    sync_q[32 + gi], sync_q[16 + gi],
                                                    sync_q[gi]});
        end
    endgenerate
    assign cur_lvl[17:16] = sync_q[81:80];
    // line 28 has no source; masking keeps it out of every path
    assign dir_lvl = {sync_q[91:82], 22'h000000} & wlc_pkg::DIRECT_BITS;

    // an unselected direction can never fire, so the select bits enable the line
    assign cfg_edge = (st_reg.rise & cur_lvl & ~st_reg.samp) |
                      (st_reg.fall & ~cur_lvl & st_reg.samp);
    assign pend_set = cfg_edge & st_reg.imask[17:0];
    assign evt_req = |(cfg_edge & st_reg.emask[17:0]) |
                     |(dir_lvl & ~st_reg.dir_prev & st_reg.emask);
    assign wake_req = |(cfg_edge & (st_reg.emask[17:0] | st_reg.imask[17:0])) |
                      |(dir_lvl & (st_reg.emask | st_reg.imask));

    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable & st_reg.ready;
    assign pend_clr = (access_ph && pwrite && paddr == wlc_pkg::OFS_PEND) ?
                      pwdata[17:0] : 18'h00000;

    always_comb begin
        st_next = st_reg;
        st_next.samp = cur_lvl;
        st_next.dir_prev = dir_lvl;
        // a new edge in the clearing cycle wins over the clear
        st_next.pend = (st_reg.pend & ~pend_clr) | pend_set;
        st_next.evt = evt_req;
        st_next.wake = wake_req;
        st_next.ready = setup_ph;
        // error flag lives only for the answer cycle, so pslverr needs no gate
        st_next.slverr = setup_ph & ~addr_hit(paddr);
        if (setup_ph) begin
            st_next.rdata = read_word(paddr, st_reg);
        end
        if (access_ph && pwrite) begin
            unique case (paddr)
                wlc_pkg::OFS_RISE: st_next.rise = pwdata[17:0];
                wlc_pkg::OFS_FALL: st_next.fall = pwdata[17:0];
                wlc_pkg::OFS_SEL_LO: st_next.sel_lo = pwdata & wlc_pkg::SEL_BITS;
                wlc_pkg::OFS_SEL_HI: st_next.sel_hi = pwdata & wlc_pkg::SEL_BITS;
                wlc_pkg::OFS_IMASK: st_next.imask = pwdata & wlc_pkg::MASK_BITS;
                wlc_pkg::OFS_EMASK: st_next.emask = pwdata & wlc_pkg::MASK_BITS;
                default: st_next.rise = st_reg.rise;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_reg.rise <= wlc_pkg::RST_RISE[17:0];
            st_reg.fall <= wlc_pkg::RST_FALL[17:0];
            st_reg.pend <= wlc_pkg::RST_PEND[17:0];
            st_reg.sel_lo <= wlc_pkg::RST_SEL;
            st_reg.sel_hi <= wlc_pkg::RST_SEL;
            st_reg.imask <= wlc_pkg::RST_IMASK;
            st_reg.emask <= wlc_pkg::RST_EMASK;
            st_reg.samp <= 18'h00000;
            st_reg.dir_prev <= 32'h00000000;
            st_reg.rdata <= 32'h00000000;
            st_reg.ready <= 1'b0;
            st_reg.slverr <= 1'b0;
            st_reg.evt <= 1'b0;
            st_reg.wake <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.rdata;
    assign pready = st_reg.ready;
    assign pslverr = st_reg.slverr;
    assign line_irq = st_reg.pend;
    assign cpu_event = st_reg.evt;
    assign cpu_wake = st_reg.wake;
    assign mux_out = st_reg.samp[15:0];

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    logic wr_pend;
    assign wr_pend = access_ph & pwrite & (paddr == wlc_pkg::OFS_PEND);

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_done;
        pready ##1 !pready;
    endsequence

    // selected rising edge on a line whose interrupt path is open
    sequence s_rise_seen;
        (st_reg.rise & cur_lvl & ~st_reg.samp & st_reg.imask[17:0]) != 18'h00000;
    endsequence

    // selected falling edge on a line whose interrupt path is open
    sequence s_fall_seen;
        (st_reg.fall & ~cur_lvl & st_reg.samp & st_reg.imask[17:0]) != 18'h00000;
    endsequence

    // pending flags
    a_pend_sets: assert property ((pend_set != 18'h00000) |=>
        ((line_irq & $past(pend_set)) == $past(pend_set)))
        else $error("selected edge did not set pending flag");

    a_pend_masked: assert property (((line_irq & ~$past(line_irq)) &
        ~$past(st_reg.imask[17:0])) == 18'h00000)
        else $error("pending flag set with interrupt mask clear");

    a_pend_clear: assert property ((wr_pend && (pend_set == 18'h00000)) |=>
        ((line_irq & $past(pwdata[17:0])) == 18'h00000))
        else $error("write one did not clear pending flag");

    a_pend_no_emask: assert property (((cfg_edge & st_reg.imask[17:0] & ~st_reg.emask[17:0])
        != 18'h00000) |=> (line_irq != 18'h00000))
        else $error("pending flag depends on event mask");

    // a held request must not drop by itself before software clears it
    a_pend_hold: assert property (((pend_set == 18'h00000) && !wr_pend) |=>
        $stable(line_irq))
        else $error("interrupt request changed without edge or clear");

    a_no_select: assert property (((line_irq & ~$past(line_irq)) &
        ~$past(st_reg.rise | st_reg.fall)) == 18'h00000)
        else $error("line without edge select raised pending");

    // edge detection
    a_rise_detect: assert property (s_rise_seen |=> ((line_irq &
        $past(st_reg.rise & cur_lvl & ~st_reg.samp)) != 18'h00000))
        else $error("selected rising edge missed");

    a_fall_detect: assert property (s_fall_seen |=> ((line_irq &
        $past(st_reg.fall & ~cur_lvl & st_reg.samp)) != 18'h00000))
        else $error("selected falling edge missed");

    // events and wake
    a_event_out: assert property (evt_req |=> cpu_event)
        else $error("event request did not reach cpu event");

    a_event_cause: assert property ($rose(cpu_event) |-> $past(evt_req))
        else $error("cpu event without masked request");

    a_wake_out: assert property (wake_req |=> cpu_wake ##1 (cpu_wake == $past(wake_req)))
        else $error("wake request not forwarded");

    // direct lines
    a_dir_wake: assert property (((dir_lvl & st_reg.imask) != 32'h00000000) |=>
        cpu_wake)
        else $error("masked-in direct line gave no wake");

    a_dir_event: assert property (((dir_lvl & ~st_reg.dir_prev & st_reg.emask)
        != 32'h00000000) |=> cpu_event)
        else $error("direct line rise gave no event");

    // gpio mux, checked on lines whose codes the bench drives
    a_mux_port_a: assert property ((st_reg.sel_lo[2:0] == wlc_pkg::PORT_A) |=>
        (mux_out[0] == $past(sync_q[0])))
        else $error("line zero mux does not follow port a");

    a_mux_port_f: assert property ((st_reg.sel_lo[10:8] == wlc_pkg::PORT_F) |=>
        (mux_out[2] == $past(sync_q[66])))
        else $error("line two mux does not follow port f");

    a_mux_no_c: assert property ((st_reg.sel_hi[26:24] == wlc_pkg::PORT_C) |=>
        !mux_out[14])
        else $error("line fourteen took unsupported port c");

    a_mux_no_d: assert property ((st_reg.sel_lo[26:24] == wlc_pkg::PORT_D) |=>
        !mux_out[6])
        else $error("line six took unsupported port d");

    // register bus
    a_apb_answer: assert property (s_setup |=> s_done)
        else $error("apb answer not one cycle wide");

    a_rsv_zero: assert property ((pready && (paddr == wlc_pkg::OFS_RISE ||
        paddr == wlc_pkg::OFS_FALL)) |-> (prdata[31:18] == 14'h0000))
        else $error("reserved select bits read nonzero");

    a_sel_rsv: assert property ((pready && (paddr == wlc_pkg::OFS_SEL_LO ||
        paddr == wlc_pkg::OFS_SEL_HI)) |-> ((prdata & ~wlc_pkg::SEL_BITS) == 32'h00000000))
        else $error("reserved port select bits read nonzero");

    a_wr_rise: assert property ((access_ph && pwrite && (paddr == wlc_pkg::OFS_RISE)) |=>
        (st_reg.rise == $past(pwdata[17:0])))
        else $error("rising select write lost");

    a_wr_fall: assert property ((access_ph && pwrite && (paddr == wlc_pkg::OFS_FALL)) |=>
        (st_reg.fall == $past(pwdata[17:0])))
        else $error("falling select write lost");
endmodule

// ==== wlc_pkg.sv ====
// register map, field layout and reset values of the wake line controller
// assumes a 32-bit apb slave port with byte addresses on paddr
package wlc_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_RISE = 12'h000;
    localparam logic [11:0] OFS_FALL = 12'h004;
    localparam logic [11:0] OFS_PEND = 12'h008;
    localparam logic [11:0] OFS_SEL_LO = 12'h050;
    localparam logic [11:0] OFS_SEL_HI = 12'h054;
    localparam logic [11:0] OFS_IMASK = 12'h070;
    localparam logic [11:0] OFS_EMASK = 12'h074;

    localparam logic [31:0] RST_RISE = 32'h00000000;
    localparam logic [31:0] RST_FALL = 32'h00000000;
    localparam logic [31:0] RST_PEND = 32'h00000000;
    localparam logic [31:0] RST_SEL = 32'h00000000;
    localparam logic [31:0] RST_IMASK = 32'hefc00000;
    localparam logic [31:0] RST_EMASK = 32'h00000000;

    // writable bits of the rise, fall, select and mask registers, the rest read zero; DIRECT_BITS marks the direct lines with a source
    localparam logic [31:0] CFG_BITS = 32'h0003ffff;
    localparam logic [31:0] MASK_BITS = 32'hefc3ffff;
    localparam logic [31:0] DIRECT_BITS = 32'hefc00000;
    localparam logic [31:0] SEL_BITS = 32'h77777777;

    localparam int CFG_LINES = 18;
    localparam int GPIO_LINES = 16;
    localparam int DIR_LINES = 10;
    localparam int DIR_FIRST = 22;
    localparam int SEL_PITCH = 4;
    localparam int SEL_FIELDS = 8;
    localparam int SYNC_W = 5 * GPIO_LINES + 2 + DIR_LINES;

    // port selection codes
    localparam logic [2:0] PORT_A = 3'h0;
    localparam logic [2:0] PORT_B = 3'h1;
    localparam logic [2:0] PORT_C = 3'h2;
    localparam logic [2:0] PORT_D = 3'h3;
    localparam logic [2:0] PORT_F = 3'h5;
    // highest lines that accept port d and port f, and the line without port c
    localparam int LAST_D_LINE = 5;
    localparam int LAST_F_LINE = 2;
    localparam int NO_C_LINE = 14;
endpackage

// ==== wlc_sync.sv ====
// two-stage synchroniser for a vector of asynchronous levels
// assumes every bit is a slow level; no bus coherency between bits
`timescale 1ns/10ps
module wlc_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } wlc_sync_st_t;

    wlc_sync_st_t st_reg;
    wlc_sync_st_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.meta = d;
        st_next.stable = st_reg.meta;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.stable;
endmodule

// ==== wlc_cpu_model.sv ====
// cpu side of the wake line controller: counts event pulses and wake requests
// assumes the controller drives registered outputs on clk_sys
`timescale 1ns/10ps
module wlc_cpu_model (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic cpu_event,
    input wire logic cpu_wake,
    output int n_event,
    output int n_wake
);
    logic wake_q;
    // sampled on the bus clock only, no second domain
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            n_event <= 0;
            n_wake <= 0;
            wake_q <= 1'b0;
        end else begin
            wake_q <= cpu_wake;
            // one count per high cycle of the event line
            if (cpu_event === 1'b1) begin
                n_event <= n_event + 1;
            end
            // a direct wake is a level, so count its rise only
            if (cpu_wake === 1'b1 && wake_q !== 1'b1) begin
                n_wake <= n_wake + 1;
            end
        end
    end
endmodule

// ==== test_wakeup_event_line_controller.sv ====
// self-checking bench of the wake line controller over apb
// assumes wlc_pkg, wlc_top and wlc_cpu_model compiled before it
`timescale 1ns/10ps
module test_wakeup_event_line_controller;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cpu_event;
    logic cpu_wake;
    logic [15:0] pins [5] = '{default: 16'h0000};
    logic [1:0] comparator_out = 2'h0;
    logic [9:0] direct_wake_req = 10'h000;
    logic [17:0] line_irq;
    logic [15:0] mux_out;
    int n_event;
    int n_wake;
    int n_fail = 0;
    int num_checks = 0;
    logic [2:0] codes [5] = '{wlc_pkg::PORT_A, wlc_pkg::PORT_B, wlc_pkg::PORT_C,
        wlc_pkg::PORT_D, wlc_pkg::PORT_F};
    logic [11:0] ofs [7] = '{wlc_pkg::OFS_RISE, wlc_pkg::OFS_FALL, wlc_pkg::OFS_PEND,
        wlc_pkg::OFS_SEL_LO, wlc_pkg::OFS_SEL_HI, wlc_pkg::OFS_IMASK, wlc_pkg::OFS_EMASK};
    logic [31:0] rst [7] = '{wlc_pkg::RST_RISE, wlc_pkg::RST_FALL, wlc_pkg::RST_PEND,
        wlc_pkg::RST_SEL, wlc_pkg::RST_SEL, wlc_pkg::RST_IMASK, wlc_pkg::RST_EMASK};

    wlc_top i_dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_a_pins(pins[0]),
        .port_b_pins(pins[1]), .port_c_pins(pins[2]), .port_d_pins(pins[3]),
        .port_f_pins(pins[4]), .comparator_out(comparator_out),
        .direct_wake_req(direct_wake_req), .line_irq(line_irq),
        .cpu_event(cpu_event), .cpu_wake(cpu_wake), .mux_out(mux_out)
    );
    wlc_cpu_model i_cpu (
        .clk_sys(clk_sys), .arst_n(arst_n), .cpu_event(cpu_event),
        .cpu_wake(cpu_wake), .n_event(n_event), .n_wake(n_wake)
    );

    always #2.5 clk_sys = ~clk_sys;

    task automatic print_verdict();
        if (n_fail == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // request held until pready is sampled high, then released
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk("pready", 32'h1, 32'h0);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(what, exp, r);
    endtask

    // comparator lines have one source, so only port slot 0 drives them
    task automatic pin(input int ln, input int p, input logic v);
        if (ln > 15) begin
            if (p == 0) begin
                comparator_out[ln-16] <= v;
            end
        end else begin
            pins[p][ln] <= v;
        end
    endtask

    function automatic logic ok(input int ln, input logic [2:0] c);
        if (ln > 15) begin
            return 1'b1;
        end
        return c == 3'h0 || c == 3'h1 || (c == 3'h2 && ln != wlc_pkg::NO_C_LINE)
            || (c == 3'h3 && ln <= wlc_pkg::LAST_D_LINE)
            || (c == 3'h5 && ln <= wlc_pkg::LAST_F_LINE);
    endfunction

    initial begin
        #(5ns * 60000);
        n_fail++;
        print_verdict();
    end

    initial begin
        logic [31:0] r;
        logic e, rb, fb, ib, eb, v;
        int ln, p, k, ev0, wk0, x;
        void'($urandom(840));
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(ofs[i], rst[i], "reset value");
        end
        apb(1'b0, 12'h00c, 32'h0, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
        wr(wlc_pkg::OFS_RISE, '1);
        rd(wlc_pkg::OFS_RISE, wlc_pkg::CFG_BITS, "rise bits");
        wr(wlc_pkg::OFS_FALL, '1);
        rd(wlc_pkg::OFS_FALL, wlc_pkg::CFG_BITS, "fall bits");
        wr(wlc_pkg::OFS_EMASK, '1);
        rd(wlc_pkg::OFS_EMASK, wlc_pkg::MASK_BITS, "event mask bits");
        for (int i = 0; i < 48; i++) begin
            x = $urandom;
            {rb, fb, ib, eb} = x[3:0];
            ln = (i < 4) ? (i == 3 ? 14 : i * 2 + 2) : $urandom % 18;
            p = (i < 4) ? 4 - (i + 1) / 2 : $urandom % 5;
            if (ln > 15) begin
                p = 0;
            end
            v = ok(ln, codes[p]);
            for (int q = 0; q < 5; q++) begin
                pin(ln, q, 1'b0);
            end
            tick(6);
            if (ln < 16) begin
                wr(ln < 8 ? wlc_pkg::OFS_SEL_LO : wlc_pkg::OFS_SEL_HI,
                   32'(codes[p]) << (4 * (ln % 8)));
            end
            wr(wlc_pkg::OFS_RISE, 32'(rb) << ln);
            wr(wlc_pkg::OFS_FALL, 32'(fb) << ln);
            wr(wlc_pkg::OFS_IMASK, 32'(ib) << ln);
            wr(wlc_pkg::OFS_EMASK, 32'(eb) << ln);
            wr(wlc_pkg::OFS_PEND, 32'h0003ffff);
            ev0 = n_event;
            wk0 = n_wake;
            for (int q = 0; q < 5; q++) begin
                if (q != p) begin
                    pin(ln, q, 1'b1);
                end
            end
            tick(6);
            chk("mux idle", 32'h0, 32'(mux_out[ln % 16] & (ln < 16)));
            pin(ln, p, 1'b1);
            tick(6);
            chk("mux out", 32'(v & (ln < 16)), 32'(mux_out[ln % 16] & (ln < 16)));
            pin(ln, p, 1'b0);
            tick(6);
            rd(wlc_pkg::OFS_PEND, 32'(v & (rb | fb) & ib) << ln, "pending");
            chk("irq", 32'(v & (rb | fb) & ib) << ln, 32'(line_irq));
            chk("events", ev0 + (v & eb) * (rb + fb), n_event);
            chk("wakes", wk0 + (v & (ib | eb)) * (rb + fb), n_wake);
            wr(wlc_pkg::OFS_PEND, 32'h1 << ln);
            tick(1);
            chk("irq cleared", 32'h0, 32'(line_irq));
        end
        wr(wlc_pkg::OFS_RISE, 32'h0);
        wr(wlc_pkg::OFS_FALL, 32'h0);
        for (int i = 0; i < 16; i++) begin
            x = $urandom;
            {ib, eb} = (i == 0) ? 2'h3 : x[1:0];
            k = (i == 0) ? 6 : $urandom % 10;
            v = (k != 6);
            wr(wlc_pkg::OFS_IMASK, 32'(ib) << (22 + k));
            wr(wlc_pkg::OFS_EMASK, 32'(eb) << (22 + k));
            ev0 = n_event;
            direct_wake_req[k] <= 1'b1;
            tick(6);
            chk("direct wake", 32'(v & (ib | eb)), 32'(cpu_wake));
            chk("direct irq", 32'h0, 32'(line_irq));
            direct_wake_req[k] <= 1'b0;
            tick(6);
            chk("direct events", ev0 + (v & eb), n_event);
        end
        print_verdict();
    end
endmodule
